// File: corr_core_defs.vh
// Constants shared by the correlation reflectometer core
`ifndef CORR_CORE_DEFS_VH
`define CORR_CORE_DEFS_VH

// Counter values: mid-scale is zero, the two ends are overflow
`define CNT_MID 16'h8000
`define CNT_TOP 16'hffff
`define CNT_BOTTOM 16'h0000
`define CNT_STEP 16'h0001

// Resolution factor reset value and its undivided code
`define RESFAC_RESET 7'h7f
`define RESFAC_UNDIV 7'h00

// Pre-delay reset value
`define PREDELAY_RESET 8'h00

// Generator register: seed and feedback taps
`define GEN_SEED 15'h0001
`define GEN_TAP_A 14
`define GEN_TAP_B 13

`endif

// File: counter_bank.v
// Bank of up/down correlation counters with registered readout
`timescale 1ns/1ps
`default_nettype none
`include "corr_core_defs.vh"

module counter_bank #(
	parameter N = 256,
	parameter AW = 8,
	parameter W = 16
) (
	// Clock and reset
	input wire clock,
	input wire rstn,
	// Counting control
	input wire count_en,
	input wire preload,
	input wire rx_bit,
	input wire [N-1:0] corr_line,
	// Per-counter disable write
	input wire dis_we,
	input wire [AW-1:0] dis_addr,
	input wire dis_val,
	// Readout
	input wire [AW-1:0] rd_addr,
	output reg [W-1:0] rd_data,
	output reg rd_dis,
	// Halt request
	output wire any_ovf
);

wire [N*W-1:0] cnt;
wire [N-1:0] disabled;
wire [N-1:0] hit;

genvar k;
generate
	for (k = 0; k < N; k = k + 1) begin : g_cnt
		localparam [AW-1:0] IDX = k;
		reg [W-1:0] val;
		reg off;
		assign cnt[k*W +: W] = val;
		assign disabled[k] = off;
		// Only enabled counters may halt the bank
		assign hit[k] = ~off &
			(val == `CNT_TOP || val == `CNT_BOTTOM);
		always @(posedge clock or negedge rstn) begin
			if (!rstn) begin
				val <= `CNT_MID;
				off <= 1'b0;
			end else begin
				if (preload)
					val <= `CNT_MID;
				else if (count_en && !off) begin
					// Match counts up, mismatch counts down
					if (rx_bit == corr_line[k])
						val <= val + `CNT_STEP;
					else
						val <= val - `CNT_STEP;
				end
				if (dis_we && dis_addr == IDX)
					off <= dis_val;
			end
		end
	end
endgenerate

assign any_ovf = |hit;

// Readout works whether running or halted
always @(posedge clock or negedge rstn) begin
	if (!rstn) begin
		rd_data <= `CNT_BOTTOM;
		rd_dis <= 1'b0;
	end else begin
		rd_data <= cnt[rd_addr*W +: W];
		rd_dis <= disabled[rd_addr];
	end
end

endmodule // counter_bank

`default_nettype wire

// File: correlation_reflectometer_core.v
// Correlation reflectometer core: generator, delay lines, control
//
// Behaviour
// - continuous pseudo-random bit drives laser power level
// - delayed transmit copy correlated against received bits
// - 256 signed sixteen-bit up/down counters
// - counter k compares bit sent k cycles earlier
// - transmit shift register adds selectable pre-delay
// - any enabled counter at ffff or 0000 halts all
// - preload sets all counters 8000, restarts
// - value 8000 means zero, offset binary
// - host may stop; counters keep their values
// - disabled counters freeze and cannot halt
// - generator rate is clock divided by 2x, full clock rate at x = 0
// - after reset, run with counters at 8000
// - status flag shows halted until restart
// - counters readable while running or halted
`timescale 1ns/1ps
`default_nettype none
`include "corr_core_defs.vh"

module correlation_reflectometer_core #(
	parameter N = 256,
	parameter AW = 8,
	parameter W = 16,
	parameter PRE_N = 256
) (
	// Clock and reset
	input wire CLOCK,
	input wire RSTN,
	// Optical front-end
	output reg LASER_BIT,
	output reg GEN_CLK,
	output reg GEN_TICK,
	input wire RX_BIT,
	// Integration control
	input wire PRELOAD,
	input wire STOP,
	output wire RUNNING,
	// Resolution factor
	input wire RESFAC_WE,
	input wire [6:0] RESFAC,
	output wire [6:0] RESFAC_NOW,
	// Transmit pre-delay
	input wire PREDELAY_WE,
	input wire [AW-1:0] PREDELAY,
	// Counter disable
	input wire DIS_WE,
	input wire [AW-1:0] DIS_ADDR,
	input wire DIS_VAL,
	// Counter readout
	input wire RD_REQ,
	input wire [AW-1:0] RD_ADDR,
	output wire [W-1:0] RD_DATA,
	output wire RD_DIS,
	output reg RD_VALID
);

// Factor zero runs the generator at the full clock rate
function undivided;
	input [6:0] x;
	begin
		undivided = (x == `RESFAC_UNDIV);
	end
endfunction

// Generator clock divider
reg [6:0] resfac;
reg [7:0] div_cnt;
wire [7:0] period_m1;
wire tick;

assign RESFAC_NOW = resfac;
assign period_m1 = {resfac, 1'b0} - 8'h01;
// Undivided when factor is zero, else one tick per 2x clocks
assign tick = undivided(resfac) || (div_cnt == period_m1);

always @(posedge CLOCK or negedge RSTN) begin
	if (!RSTN) begin
		resfac <= `RESFAC_RESET;
		div_cnt <= 8'h00;
	end else begin
		if (RESFAC_WE) begin
			resfac <= RESFAC;
			div_cnt <= 8'h00;
		end else if (tick)
			div_cnt <= 8'h00;
		else
			div_cnt <= div_cnt + 8'h01;
	end
end

// Generator clock shape: high for the first half of each divided period; toggles every clock when undivided
always @(posedge CLOCK or negedge RSTN) begin
	if (!RSTN) begin
		GEN_CLK <= 1'b0;
		GEN_TICK <= 1'b0;
	end else begin
		GEN_TICK <= tick;
		if (undivided(resfac))
			GEN_CLK <= ~GEN_CLK;
		else
			GEN_CLK <= (div_cnt < {1'b0, resfac});
	end
end

// Pseudo-random generator, runs regardless of integration state
reg [14:0] lfsr;
wire fb;

assign fb = lfsr[`GEN_TAP_A] ^ lfsr[`GEN_TAP_B];

always @(posedge CLOCK or negedge RSTN) begin
	if (!RSTN) begin
		lfsr <= `GEN_SEED;
		LASER_BIT <= 1'b0;
	end else if (tick) begin
		lfsr <= {lfsr[13:0], fb};
		// 0 is low laser power, 1 is high laser power
		LASER_BIT <= lfsr[14];
	end
end

// Transmit pre-delay line: hist[j] is the bit sent j+1 ticks ago.
// The deepest pre-delay reads hist[PRE_N-2], so no further stage.
// A new pre-delay mixes old and new taps for N-1 ticks; preload after it.
reg [PRE_N-2:0] hist;
reg [AW-1:0] predelay;
wire delayed;
// Pre-delay reset value narrowed to the address width (AW up to 8)
localparam [7:0] PREDELAY_WIDE = `PREDELAY_RESET;
localparam [AW-1:0] PREDELAY_INIT = PREDELAY_WIDE[AW-1:0];

always @(posedge CLOCK or negedge RSTN) begin
	if (!RSTN) begin
		hist <= {(PRE_N-1){1'b0}};
		predelay <= PREDELAY_INIT;
	end else begin
		if (PREDELAY_WE)
			predelay <= PREDELAY;
		if (tick)
			hist <= {hist[PRE_N-3:0], LASER_BIT};
	end
end

assign delayed = (predelay == PREDELAY_INIT) ? LASER_BIT :
	hist[predelay - 1'b1];

// Correlator line: tap k is the pre-delayed bit from k ticks ago
reg [N-2:0] corr_reg;
wire [N-1:0] corr_line;

always @(posedge CLOCK or negedge RSTN) begin
	if (!RSTN)
		corr_reg <= {(N-1){1'b0}};
	else if (tick)
		corr_reg <= {corr_reg[N-3:0], delayed};
end

assign corr_line = {corr_reg, delayed};

// Integration state
reg running;
reg next_running;
wire any_ovf;
wire count_en;

// Counting is also blocked combinationally so a counter at an end
// never wraps in the cycle before the halt takes effect
assign count_en = running & tick & ~any_ovf & ~STOP & ~PRELOAD;
assign RUNNING = running;

// Halt on an end value or a host stop; values stay for readout
always @* begin
	next_running = running;
	if (any_ovf)
		next_running = 1'b0;
	if (STOP)
		next_running = 1'b0;
	// Restart wins over stop and over a pending end value
	if (PRELOAD)
		next_running = 1'b1;
end

always @(posedge CLOCK or negedge RSTN) begin
	if (!RSTN)
		running <= 1'b1;
	else
		running <= next_running;
end

// Readout strobe follows the registered data by construction
always @(posedge CLOCK or negedge RSTN) begin
	if (!RSTN)
		RD_VALID <= 1'b0;
	else
		RD_VALID <= RD_REQ;
end

// Counters with registered readout; any_ovf comes back to halt
counter_bank #(
	.N(N),
	.AW(AW),
	.W(W)
) u_bank (
	.clock(CLOCK),
	.rstn(RSTN),
	.count_en(count_en),
	.preload(PRELOAD),
	.rx_bit(RX_BIT),
	.corr_line(corr_line),
	.dis_we(DIS_WE),
	.dis_addr(DIS_ADDR),
	.dis_val(DIS_VAL),
	.rd_addr(RD_ADDR),
	.rd_data(RD_DATA),
	.rd_dis(RD_DIS),
	.any_ovf(any_ovf)
);

endmodule // correlation_reflectometer_core

`default_nettype wire

// File: corr_sva.sv
// Port checker for the reflectometer core
`timescale 1ns/1ps
`default_nettype none
module corr_sva #(parameter AW = 8, parameter W = 16) (
	// Clock and reset
	input wire logic CLOCK, RSTN,
	// Watched ports
	input wire logic LASER_BIT, GEN_TICK, GEN_CLK, PRELOAD, STOP, RUNNING,
	input wire logic RESFAC_WE, RD_REQ, RD_VALID,
	input wire logic [6:0] RESFAC, RESFAC_NOW,
	input wire logic [AW-1:0] RD_ADDR,
	input wire logic [W-1:0] RD_DATA
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RSTN);
	property p_stop; STOP && !PRELOAD |=> !RUNNING; endproperty
	a_stop: assert property (p_stop) else $error("stop ignored");
	property p_pre; PRELOAD |=> RUNNING; endproperty
	a_pre: assert property (p_pre) else $error("no restart");
	property p_hold; !RUNNING && !PRELOAD |=> !RUNNING; endproperty
	a_hold: assert property (p_hold) else $error("left halt");
	property p_valid; RD_REQ |=> RD_VALID ##1 !RD_VALID || $past(RD_REQ);
	endproperty
	a_valid: assert property (p_valid) else $error("read pulse");
	property p_fac; RESFAC_WE |=> RESFAC_NOW == $past(RESFAC); endproperty
	a_fac: assert property (p_fac) else $error("factor");
	property p_tick; (RESFAC_NOW == 7'h00)[*2] |-> GEN_TICK; endproperty
	a_tick: assert property (p_tick) else $error("undivided");
	property p_laser; $changed(LASER_BIT) |-> GEN_TICK; endproperty
	a_laser: assert property (p_laser) else $error("bit moved");
	property p_frozen;
		!RUNNING && !PRELOAD ##1 $stable(RD_ADDR) |=> $stable(RD_DATA);
	endproperty
	a_frozen: assert property (p_frozen) else $error("counted");
	property p_gclk; RESFAC_NOW == 7'h00 |=> GEN_CLK != $past(GEN_CLK);
	endproperty
	a_gclk: assert property (p_gclk) else $error("gen clock");
	property p_zero; PRELOAD |-> ##2 RD_DATA == 16'h8000; endproperty
	a_zero: assert property (p_zero) else $error("not zero");
endmodule // corr_sva
`default_nettype wire

// File: echo_front_end.sv
// Optical front-end model: one reflection a few ticks away
`timescale 1ns/1ps
`default_nettype none
module echo_front_end #(parameter DLY = 5) (
	// Clock and reset
	input wire logic CLOCK, RSTN,
	// Laser side and receiver
	input wire logic LASER_BIT, GEN_TICK,
	output logic RX_BIT
);
	logic [15:0] hist;
	always @(posedge CLOCK or negedge RSTN)
		if (!RSTN) hist <= 16'h0000;
		else if (GEN_TICK) hist <= {hist[14:0], LASER_BIT};
	assign RX_BIT = hist[DLY];
endmodule // echo_front_end
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the reflectometer core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic CLOCK = 0, RSTN = 0, RX_BIT, PRELOAD = 0, STOP = 0, DIS_VAL = 0;
	logic RESFAC_WE = 0, DIS_WE = 0, RD_REQ = 0, LASER_BIT, GEN_CLK;
	logic GEN_TICK, RUNNING, RD_DIS, RD_VALID;
	logic [6:0] RESFAC = 7'h00, RESFAC_NOW, r;
	logic [3:0] DIS_ADDR = 4'h0, RD_ADDR = 4'h0, PREDELAY = 4'h0, p;
	logic PREDELAY_WE = 0;
	logic [15:0] RD_DATA, v;
	int fails = 0, checked = 0, i, found, n, hi, m;
	// Partner echo: its DLY ticks plus its own register stage
	localparam int ECHO = 6;
	always #20 CLOCK = ~CLOCK;
	correlation_reflectometer_core #(.N(16), .AW(4), .PRE_N(16)) i_dut (
		.CLOCK(CLOCK), .RSTN(RSTN), .LASER_BIT(LASER_BIT), .GEN_CLK(GEN_CLK),
		.GEN_TICK(GEN_TICK), .RX_BIT(RX_BIT), .PRELOAD(PRELOAD), .STOP(STOP),
		.RUNNING(RUNNING), .RESFAC_WE(RESFAC_WE), .RESFAC(RESFAC),
		.RESFAC_NOW(RESFAC_NOW), .PREDELAY_WE(PREDELAY_WE),
		.PREDELAY(PREDELAY),
		.DIS_WE(DIS_WE), .DIS_ADDR(DIS_ADDR), .DIS_VAL(DIS_VAL),
		.RD_REQ(RD_REQ), .RD_ADDR(RD_ADDR), .RD_DATA(RD_DATA),
		.RD_DIS(RD_DIS), .RD_VALID(RD_VALID));
	echo_front_end #(.DLY(ECHO - 1)) i_fe (.CLOCK(CLOCK), .RSTN(RSTN),
		.LASER_BIT(LASER_BIT), .GEN_TICK(GEN_TICK), .RX_BIT(RX_BIT));
	task chk(input string n, input logic [15:0] e, s);
		checked++;
		if (s !== e) begin
			fails++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask
	function automatic int exp_per(input logic [6:0] x);
		return (x == 7'h00) ? 1 : 2 * x;
	endfunction
	function automatic logic [15:0] exp_cnt(input int steps);
		return 16'h8000 + 16'(steps);
	endfunction
	// Clocks from one tick pulse to the next, and GEN_CLK highs among them
	task per_meas(output int pn, output int ph);
		pn = 0;
		ph = 0;
		while (GEN_TICK !== 1'b1) @(negedge CLOCK);
		do begin
			@(negedge CLOCK);
			pn++;
			ph += GEN_CLK;
		end while (GEN_TICK !== 1'b1 && pn < 300);
	endtask
	task rd(input logic [3:0] a);
		@(negedge CLOCK) RD_REQ = 1;
		RD_ADDR = a;
		@(negedge CLOCK) RD_REQ = 0;
		chk("valid", 16'h1, {15'h0, RD_VALID});
	endtask
	task ctl(input logic [1:0] m);
		@(negedge CLOCK) {PRELOAD, STOP} = m;
		@(negedge CLOCK) {PRELOAD, STOP} = 2'b00;
	endtask
	task dis(input logic [3:0] a, input logic d);
		@(negedge CLOCK) DIS_WE = 1;
		DIS_ADDR = a;
		DIS_VAL = d;
		@(negedge CLOCK) DIS_WE = 0;
	endtask
	task final_report;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		#3000000;
		fails++;
		final_report;
	end
	initial begin
		void'($urandom(72));
		repeat (20) @(negedge CLOCK);
		RSTN = 1;
		chk("run", 16'h1, {15'h0, RUNNING});
		chk("fac", 16'h7f, {9'h0, RESFAC_NOW});
		for (i = 0; i < 16; i++) begin
			rd(i);
			chk("cnt", 16'h8000, RD_DATA);
		end
		$display("reset test done");
		for (i = 0; i < 5; i++) begin
			r = (i == 4) ? 7'h00 : 7'($urandom);
			@(negedge CLOCK) RESFAC_WE = 1;
			RESFAC = r;
			@(negedge CLOCK) RESFAC_WE = 0;
			chk("fac", {9'h0, r}, {9'h0, RESFAC_NOW});
			per_meas(n, hi);
			chk("per", 16'(exp_per(r)), 16'(n));
			if (r != 7'h00) chk("high", {9'h0, r}, 16'(hi));
		end
		$display("factor test done");
		ctl(2'b01);
		chk("run", 16'h0, {15'h0, RUNNING});
		rd(4'($urandom));
		v = RD_DATA;
		repeat (9) @(negedge CLOCK);
		rd(RD_ADDR);
		chk("held", v, RD_DATA);
		$display("stop test done");
		for (i = 0; i < 16; i++) dis(i, 1);
		ctl(2'b11);
		chk("run", 16'h1, {15'h0, RUNNING});
		repeat (5) @(negedge CLOCK);
		for (i = 0; i < 16; i++) begin
			rd(i);
			chk("cnt", 16'h8000, RD_DATA);
			chk("dis", 16'h1, {15'h0, RD_DIS});
		end
		$display("disable test done");
		for (i = 0; i < 16; i++) dis(i, 0);
		for (i = 0; i < 40000 && RUNNING === 1'b1; i++) @(negedge CLOCK);
		chk("run", 16'h0, {15'h0, RUNNING});
		found = 0;
		for (i = 0; i < 16; i++) begin
			rd(i);
			if (RD_DATA === 16'hffff) found++;
			if (i == ECHO) chk("ovf", 16'hffff, RD_DATA);
			chk("dis", 16'h0, {15'h0, RD_DIS});
		end
		chk("ovf", 16'h1, {15'h0, found != 0});
		ctl(2'b10);
		chk("run", 16'h1, {15'h0, RUNNING});
		$display("overflow test done");
		p = 4'(1 + $urandom % 5);
		m = 40 + $urandom % 100;
		@(negedge CLOCK) PREDELAY_WE = 1;
		PREDELAY = p;
		@(negedge CLOCK) PREDELAY_WE = 0;
		repeat (20) @(negedge CLOCK);
		ctl(2'b10);
		repeat (m) @(negedge CLOCK);
		ctl(2'b01);
		rd(4'(ECHO - p));
		chk("pre", exp_cnt(m + 1), RD_DATA);
		$display("predelay test done");
		final_report;
	end
endmodule // tb_top
bind correlation_reflectometer_core corr_sva #(.AW(AW), .W(W)) i_sva (
	.CLOCK(CLOCK), .RSTN(RSTN), .LASER_BIT(LASER_BIT), .GEN_TICK(GEN_TICK),
	.GEN_CLK(GEN_CLK),
	.PRELOAD(PRELOAD), .STOP(STOP), .RUNNING(RUNNING),
	.RESFAC_WE(RESFAC_WE), .RD_REQ(RD_REQ), .RD_VALID(RD_VALID),
	.RESFAC(RESFAC), .RESFAC_NOW(RESFAC_NOW), .RD_ADDR(RD_ADDR),
	.RD_DATA(RD_DATA));
`default_nettype wire
